// ===== hw/tfm_pkg.sv
// constants for the terminal function-select multiplexer
// assumes one system clock; pad indices match the pad vectors of tfm_mux
package tfm_pkg;

   typedef enum logic [2:0] {
      TFM_SEL_PRI  = 3'h0,
      TFM_SEL_ALT1 = 3'h1,
      TFM_SEL_ALT2 = 3'h3,
      TFM_SEL_ALT3 = 3'h2
   } tfm_sel_t;

   // codes as seen in the select fields (enum carries gray order only)
   localparam logic [2:0] TFM_CODE_PRI  = 3'h0;
   localparam logic [2:0] TFM_CODE_ALT1 = 3'h1;
   localparam logic [2:0] TFM_CODE_ALT2 = 3'h2;
   localparam logic [2:0] TFM_CODE_ALT3 = 3'h3;

   localparam logic [31:0] TFM_SEL_RST = 32'h0000_0000;

   // field positions in function_select_register seven
   localparam int TFM_F7_GP1 = 6;
   localparam int TFM_F7_GP0 = 9;
   localparam int TFM_F7_IO5 = 12;
   localparam int TFM_F7_IO4 = 15;
   localparam int TFM_F7_IO2 = 18;
   // field positions in function_select_register eight
   localparam int TFM_F8_SDI = 0;
   localparam int TFM_F8_SDO = 3;
   localparam int TFM_F8_SCK = 6;
   localparam int TFM_F8_CS0 = 9;
   localparam int TFM_F8_CS3 = 12;

   // pad indices
   localparam int TFM_P_GP1  = 0;
   localparam int TFM_P_GP0  = 1;
   localparam int TFM_P_IO5  = 2;
   localparam int TFM_P_IO4  = 3;
   localparam int TFM_P_IO2  = 4;
   localparam int TFM_P_IO1  = 5;
   localparam int TFM_P_SCL  = 6;
   localparam int TFM_P_SDA  = 7;
   localparam int TFM_P_SDI  = 8;
   localparam int TFM_P_SDO  = 9;
   localparam int TFM_P_SCK  = 10;
   localparam int TFM_P_CS0  = 11;
   localparam int TFM_P_CS3  = 12;
   localparam int TFM_P_TDO  = 13;
   localparam int TFM_NPAD   = 14;

   localparam logic [13:0] TFM_PAD_RST_OE  = 14'h2600;
   localparam logic [13:0] TFM_PAD_RST_OUT = 14'h0000;
   localparam logic [13:0] TFM_PAD_G1      = 14'h061f;
   localparam logic [13:0] TFM_PAD_H1      = 14'h00c0;

   // fixed-function input pins
   localparam int TFM_X_BATTERY_FAIL_IN = 0;
   localparam int TFM_X_SLOW  = 1;
   localparam int TFM_X_CONFIGURATION_STRAP_IN  = 2;
   localparam int TFM_X_TDI   = 3;
   localparam int TFM_X_TMS   = 4;
   localparam int TFM_X_TCK   = 5;
   localparam int TFM_X_TRST  = 6;
   localparam int TFM_X_POR   = 7;
   localparam int TFM_NFIX    = 8;

   // input-function vector
   localparam int TFM_FN_GP1  = 0;
   localparam int TFM_FN_GP0  = 1;
   localparam int TFM_FN_RDY  = 2;
   localparam int TFM_FN_VBUS = 3;
   localparam int TFM_FN_IO5  = 4;
   localparam int TFM_FN_IO4  = 5;
   localparam int TFM_FN_DMA1 = 6;
   localparam int TFM_FN_IO2  = 7;
   localparam int TFM_FN_DMA0 = 8;
   localparam int TFM_FN_IO1  = 9;
   localparam int TFM_FN_SDI  = 10;
   localparam int TFM_FN_DSR3 = 11;
   localparam int TFM_FN_DSR1 = 12;
   localparam int TFM_FN_BDR  = 13;
   localparam int TFM_FN_CLKX = 14;
   localparam int TFM_NFN     = 15;

   // deselected levels; also the reset value of the function inputs
   localparam logic [14:0] TFM_FN_DESEL = 15'h1800;

endpackage : tfm_pkg

// ===== hw/tfm_sync2.sv
// two-flop level synchroniser for pin inputs
// assumes the input is asynchronous to clk_sys
module tfm_sync2
   import tfm_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta_reg;
   logic sync_reg;

   // meta_reg feeds only sync_reg
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule // tfm_sync2

// ===== hw/tfm_pad.sv
// one pad: registered drive and enable, synchronised input level
// assumes the pad ring resolves the wire from pin_out and pin_oe
module tfm_pad
   import tfm_pkg::*;
#(
   parameter logic RST_OE  = 1'b0,
   parameter logic RST_OUT = 1'b0
)(
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      pin_oe,
   input  wire logic out_next,
   input  wire logic oe_next,
   output logic      level
);

   logic out_reg;
   logic oe_reg;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         out_reg <= RST_OUT;
         oe_reg  <= RST_OE;
      end else begin
         out_reg <= out_next;
         oe_reg  <= oe_next;
      end
   end

   assign pin_out = out_reg;
   assign pin_oe  = oe_reg;

   tfm_sync2 u_sync (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .async_in (pin_in),
      .sync_out (level)
   );

endmodule // tfm_pad

// ===== hw/tfm_mux.sv
// terminal function-select multiplexer for one pin group
// assumes pins resolve from pad_out/pad_oe; select writes from clk_sys logic
// Contract
// R1: three-bit field picks function, 000 primary
// R2: reg7 8:6 general pin one or rts
// R3: reg7 11:9 pin zero, ready, power sense
// R4: reg7 14:12 io five or low-power
// R5: reg7 17:15 io four, request one, lamp
// R6: reg7 20:18 io two or request zero
// R7: reg8 2:0 input select, set-ready idles high
// R8: reg8 5:3 serial output select, low reset
// R9: reg8 8:6 serial clock or column seven
// R10: reg8 11:9 high-z, select zero, tx clock
// R11: reg8 14:12 high-z, select three, column six
// R12: fixed pins have no select field
// R13: two-wire pins fixed, high-z, fail tristates
// R14: marked outputs gated by battery fail
// R15: class two and three gate terms
// R16: reset: bidirectionals input, serial outputs low
// R17: test data out driven low in reset
// R18: fields reset 000; unlisted codes stay safe
// R19: unselected input consumers see deselected level
module tfm_mux
   import tfm_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic [31:0] function_select_7_wdata,
   input  wire logic        function_select_7_we,
   input  wire logic [31:0] function_select_8_wdata,
   input  wire logic        function_select_8_we,
   output logic      [31:0] function_select_7_rdata,
   output logic      [31:0] function_select_8_rdata,
   input  wire logic [13:0] pad_in,
   output logic      [13:0] pad_out,
   output logic      [13:0] pad_oe,
   input  wire logic [7:0]  fixed_pin_in,
   output logic      [7:0]  fixed_pin_level,
   input  wire logic [1:0]  general_pin_o,
   input  wire logic [1:0]  general_pin_oe,
   output logic      [1:0]  general_pin_i,
   input  wire logic [3:0]  proc_io_o,
   input  wire logic [3:0]  proc_io_oe,
   output logic      [3:0]  proc_io_i,
   input  wire logic        serial_c_request_to_send,
   output logic             serial_periph_ready,
   output logic             bus_power_sense,
   input  wire logic        low_power_indicator,
   output logic             external_transfer_request_one,
   output logic             external_transfer_request_zero,
   input  wire logic        indicator_lamp_two,
   output logic             three_wire_data_in,
   input  wire logic        three_wire_data_out,
   input  wire logic        three_wire_clock_out,
   input  wire logic        three_wire_select_zero,
   input  wire logic        three_wire_select_three,
   output logic             serial_c_set_ready,
   output logic             serial_a_set_ready,
   input  wire logic        serial_c_terminal_ready,
   input  wire logic        serial_a_terminal_ready,
   output logic             buffered_port_c_rx_data,
   input  wire logic        buffered_port_c_tx_data,
   input  wire logic        buffered_port_c_tx_clock_o,
   input  wire logic        buffered_port_c_tx_clock_oe,
   output logic             buffered_port_c_tx_clock_i,
   input  wire logic        keypad_column_seven,
   input  wire logic        keypad_column_six,
   input  wire logic        two_wire_clock_pull_low,
   input  wire logic        two_wire_data_pull_low,
   output logic             two_wire_clock_i,
   output logic             two_wire_data_i,
   input  wire logic        test_data_out,
   input  wire logic        general_pin_nine_level,
   input  wire logic        proc_io_line_three_level,
   output logic             gate_class_two,
   output logic             gate_class_three
);

   logic [31:0] sel7_reg, sel7_next;
   logic [31:0] sel8_reg, sel8_next;
   logic [13:0] out_next, oe_next, lvl;
   logic [14:0] fn_reg, fn_next;
   logic [2:0]  s_gp1, s_gp0, s_io5, s_io4, s_io2;
   logic [2:0]  s_sdi, s_sdo, s_sck, s_cs0, s_cs3;
   logic        battery_fail_in;

   // select registers
   always_comb begin
      sel7_next = function_select_7_we ? function_select_7_wdata : sel7_reg;
      sel8_next = function_select_8_we ? function_select_8_wdata : sel8_reg;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sel7_reg <= TFM_SEL_RST; // R18
         sel8_reg <= TFM_SEL_RST; // R18
         fn_reg   <= TFM_FN_DESEL;
      end else begin
         sel7_reg <= sel7_next;
         sel8_reg <= sel8_next;
         fn_reg   <= fn_next;
      end
   end

   assign function_select_7_rdata = sel7_reg;
   assign function_select_8_rdata = sel8_reg;

   assign s_gp1 = sel7_reg[TFM_F7_GP1 +: 3]; // R1
   assign s_gp0 = sel7_reg[TFM_F7_GP0 +: 3];
   assign s_io5 = sel7_reg[TFM_F7_IO5 +: 3];
   assign s_io4 = sel7_reg[TFM_F7_IO4 +: 3];
   assign s_io2 = sel7_reg[TFM_F7_IO2 +: 3];
   assign s_sdi = sel8_reg[TFM_F8_SDI +: 3];
   assign s_sdo = sel8_reg[TFM_F8_SDO +: 3];
   assign s_sck = sel8_reg[TFM_F8_SCK +: 3];
   assign s_cs0 = sel8_reg[TFM_F8_CS0 +: 3];
   assign s_cs3 = sel8_reg[TFM_F8_CS3 +: 3];

   // fixed-function inputs only pass the synchroniser
   for (genvar i = 0; i < TFM_NFIX; i++) begin : g_fix
      tfm_sync2 u_sync ( // R12
         .clk_sys  (clk_sys),
         .sys_rst  (sys_rst),
         .async_in (fixed_pin_in[i]),
         .sync_out (fixed_pin_level[i])
      );
   end

   assign battery_fail_in            = fixed_pin_level[TFM_X_BATTERY_FAIL_IN];
   assign gate_class_two   = general_pin_nine_level
                           & proc_io_line_three_level; // R15
   assign gate_class_three = battery_fail_in & fixed_pin_level[TFM_X_POR]; // R15

   // pad drive; unlisted codes fall back to primary or high-z
   always_comb begin
      out_next = '0;
      oe_next  = '0;
      if (s_gp1 == TFM_CODE_ALT1) begin // R2
         out_next[TFM_P_GP1] = serial_c_request_to_send;
         oe_next[TFM_P_GP1]  = 1'b1;
      end else begin // R18
         out_next[TFM_P_GP1] = general_pin_o[1];
         oe_next[TFM_P_GP1]  = general_pin_oe[1];
      end
      if (s_gp0 != TFM_CODE_ALT1 && s_gp0 != TFM_CODE_ALT2) begin // R3
         out_next[TFM_P_GP0] = general_pin_o[0];
         oe_next[TFM_P_GP0]  = general_pin_oe[0];
      end
      if (s_io5 == TFM_CODE_ALT1) begin // R4
         out_next[TFM_P_IO5] = low_power_indicator;
         oe_next[TFM_P_IO5]  = 1'b1;
      end else begin
         out_next[TFM_P_IO5] = proc_io_o[3];
         oe_next[TFM_P_IO5]  = proc_io_oe[3];
      end
      if (s_io4 == TFM_CODE_ALT2) begin // R5
         out_next[TFM_P_IO4] = indicator_lamp_two;
         oe_next[TFM_P_IO4]  = 1'b1;
      end else if (s_io4 != TFM_CODE_ALT1) begin
         out_next[TFM_P_IO4] = proc_io_o[2];
         oe_next[TFM_P_IO4]  = proc_io_oe[2];
      end
      if (s_io2 != TFM_CODE_ALT1) begin // R6
         out_next[TFM_P_IO2] = proc_io_o[1];
         oe_next[TFM_P_IO2]  = proc_io_oe[1];
      end
      out_next[TFM_P_IO1] = proc_io_o[0]; // R12
      oe_next[TFM_P_IO1]  = proc_io_oe[0];
      // open drain: only ever drives low
      oe_next[TFM_P_SCL] = two_wire_clock_pull_low; // R13
      oe_next[TFM_P_SDA] = two_wire_data_pull_low; // R13
      oe_next[TFM_P_SDO] = 1'b1;
      if (s_sdo == TFM_CODE_ALT1) begin // R8
         out_next[TFM_P_SDO] = serial_c_terminal_ready;
      end else if (s_sdo == TFM_CODE_ALT2) begin
         out_next[TFM_P_SDO] = serial_a_terminal_ready;
      end else if (s_sdo == TFM_CODE_ALT3) begin
         out_next[TFM_P_SDO] = buffered_port_c_tx_data;
      end else begin
         out_next[TFM_P_SDO] = three_wire_data_out;
      end
      oe_next[TFM_P_SCK] = 1'b1;
      if (s_sck == TFM_CODE_ALT1) begin // R9
         out_next[TFM_P_SCK] = keypad_column_seven;
      end else begin
         out_next[TFM_P_SCK] = three_wire_clock_out;
      end
      if (s_cs0 == TFM_CODE_ALT1) begin // R10
         out_next[TFM_P_CS0] = three_wire_select_zero;
         oe_next[TFM_P_CS0]  = 1'b1;
      end else if (s_cs0 == TFM_CODE_ALT2) begin
         out_next[TFM_P_CS0] = buffered_port_c_tx_clock_o;
         oe_next[TFM_P_CS0]  = buffered_port_c_tx_clock_oe;
      end
      if (s_cs3 == TFM_CODE_ALT1) begin // R11
         out_next[TFM_P_CS3] = three_wire_select_three;
         oe_next[TFM_P_CS3]  = 1'b1;
      end else if (s_cs3 == TFM_CODE_ALT2) begin
         out_next[TFM_P_CS3] = keypad_column_six;
         oe_next[TFM_P_CS3]  = 1'b1;
      end
      out_next[TFM_P_TDO] = test_data_out; // R17
      oe_next[TFM_P_TDO]  = 1'b1;
      // G1 pins keep their enable and hold low; H1 two-wire pins are released to high-z
      out_next = out_next & ~(TFM_PAD_G1 & {TFM_NPAD{battery_fail_in}}); // R14
      oe_next  = oe_next & ~(TFM_PAD_H1 & {TFM_NPAD{battery_fail_in}}); // R13
   end

   for (genvar p = 0; p < TFM_NPAD; p++) begin : g_pad
      tfm_pad #(
         .RST_OE  (TFM_PAD_RST_OE[p]), // R16
         .RST_OUT (TFM_PAD_RST_OUT[p])
      ) u_pad (
         .clk_sys  (clk_sys),
         .sys_rst  (sys_rst),
         .pin_in   (pad_in[p]),
         .pin_out  (pad_out[p]),
         .pin_oe   (pad_oe[p]),
         .out_next (out_next[p]),
         .oe_next  (oe_next[p]),
         .level    (lvl[p])
      );
   end

   // input functions: selected one sees the pin, others their idle level
   always_comb begin
      fn_next = TFM_FN_DESEL; // R19
      fn_next[TFM_FN_GP1]  = (s_gp1 != TFM_CODE_ALT1) & lvl[TFM_P_GP1];
      fn_next[TFM_FN_GP0]  = (s_gp0 != TFM_CODE_ALT1)
                           & (s_gp0 != TFM_CODE_ALT2) & lvl[TFM_P_GP0];
      fn_next[TFM_FN_RDY]  = (s_gp0 == TFM_CODE_ALT1) & lvl[TFM_P_GP0]; // R3
      fn_next[TFM_FN_VBUS] = (s_gp0 == TFM_CODE_ALT2) & lvl[TFM_P_GP0]; // R3
      fn_next[TFM_FN_IO5]  = (s_io5 != TFM_CODE_ALT1) & lvl[TFM_P_IO5];
      fn_next[TFM_FN_IO4]  = (s_io4 != TFM_CODE_ALT1)
                           & (s_io4 != TFM_CODE_ALT2) & lvl[TFM_P_IO4];
      fn_next[TFM_FN_DMA1] = (s_io4 == TFM_CODE_ALT1) & lvl[TFM_P_IO4]; // R5
      fn_next[TFM_FN_IO2]  = (s_io2 != TFM_CODE_ALT1) & lvl[TFM_P_IO2];
      fn_next[TFM_FN_DMA0] = (s_io2 == TFM_CODE_ALT1) & lvl[TFM_P_IO2]; // R6
      fn_next[TFM_FN_IO1]  = lvl[TFM_P_IO1];
      fn_next[TFM_FN_SDI]  = (s_sdi != TFM_CODE_ALT1)
                           & (s_sdi != TFM_CODE_ALT2)
                           & (s_sdi != TFM_CODE_ALT3) & lvl[TFM_P_SDI]; // R7
      if (s_sdi == TFM_CODE_ALT1) begin // R7
         fn_next[TFM_FN_DSR3] = lvl[TFM_P_SDI];
      end
      if (s_sdi == TFM_CODE_ALT2) begin // R7
         fn_next[TFM_FN_DSR1] = lvl[TFM_P_SDI];
      end
      fn_next[TFM_FN_BDR]  = (s_sdi == TFM_CODE_ALT3) & lvl[TFM_P_SDI];
      fn_next[TFM_FN_CLKX] = (s_cs0 == TFM_CODE_ALT2) & lvl[TFM_P_CS0];
   end

   assign general_pin_i  = {fn_reg[TFM_FN_GP1], fn_reg[TFM_FN_GP0]};
   assign proc_io_i      = {fn_reg[TFM_FN_IO5], fn_reg[TFM_FN_IO4],
                            fn_reg[TFM_FN_IO2], fn_reg[TFM_FN_IO1]};
   assign serial_periph_ready            = fn_reg[TFM_FN_RDY];
   assign bus_power_sense                = fn_reg[TFM_FN_VBUS];
   assign external_transfer_request_one  = fn_reg[TFM_FN_DMA1];
   assign external_transfer_request_zero = fn_reg[TFM_FN_DMA0];
   assign three_wire_data_in             = fn_reg[TFM_FN_SDI];
   assign serial_c_set_ready             = fn_reg[TFM_FN_DSR3];
   assign serial_a_set_ready             = fn_reg[TFM_FN_DSR1];
   assign buffered_port_c_rx_data        = fn_reg[TFM_FN_BDR];
   assign buffered_port_c_tx_clock_i     = fn_reg[TFM_FN_CLKX];
   assign two_wire_clock_i               = lvl[TFM_P_SCL];
   assign two_wire_data_i                = lvl[TFM_P_SDA];

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_rts_sel;
      s_gp1 == TFM_CODE_ALT1 && !battery_fail_in;
   endsequence
   sequence s_rts_driven;
      pad_oe[TFM_P_GP1]
         && pad_out[TFM_P_GP1] == $past(serial_c_request_to_send);
   endsequence
   property p_r2;
      s_rts_sel |=> s_rts_driven;
   endproperty
   a_r2: assert property (p_r2) else $error("rts not on pin"); // R2

   property p_r3;
      s_gp0 != TFM_CODE_ALT2 |=> !bus_power_sense;
   endproperty
   a_r3: assert property (p_r3) else $error("power sense not idle"); // R3

   property p_r4;
      s_io5 == TFM_CODE_ALT1 && !battery_fail_in
         |=> pad_out[TFM_P_IO5] == $past(low_power_indicator);
   endproperty
   a_r4: assert property (p_r4) else $error("low power not on pin"); // R4

   property p_r5;
      s_io4 == TFM_CODE_ALT1 ##1 s_io4 == TFM_CODE_ALT1
         |=> external_transfer_request_one == $past(lvl[TFM_P_IO4])
             && !pad_oe[TFM_P_IO4];
   endproperty
   a_r5: assert property (p_r5) else $error("request one wrong"); // R5

   property p_r7;
      s_sdi != TFM_CODE_ALT1 |=> serial_c_set_ready;
   endproperty
   a_r7: assert property (p_r7) else $error("set ready not high"); // R7

   property p_r8;
      s_sdo == TFM_CODE_ALT3 && !battery_fail_in
         |=> pad_oe[TFM_P_SDO]
             && pad_out[TFM_P_SDO] == $past(buffered_port_c_tx_data);
   endproperty
   a_r8: assert property (p_r8) else $error("tx data not on pin"); // R8

   property p_r10;
      s_cs0 == TFM_CODE_PRI |=> !pad_oe[TFM_P_CS0];
   endproperty
   a_r10: assert property (p_r10) else $error("select pin not high-z"); // R10

   property p_r11;
      s_cs3 == TFM_CODE_ALT2
         |=> pad_oe[TFM_P_CS3]
             && pad_out[TFM_P_CS3] == $past(keypad_column_six);
   endproperty
   a_r11: assert property (p_r11) else $error("column six not on pin"); // R11

   property p_r13;
      battery_fail_in |=> !pad_oe[TFM_P_SCL] && !pad_oe[TFM_P_SDA]
                && !pad_out[TFM_P_SCL];
   endproperty
   a_r13: assert property (p_r13) else $error("two-wire not released"); // R13

   property p_r14;
      battery_fail_in |=> !pad_out[TFM_P_SDO] && !pad_out[TFM_P_SCK];
   endproperty
   a_r14: assert property (p_r14) else $error("gated output high"); // R14

   property p_r18;
      s_cs3 > TFM_CODE_ALT2 |=> !pad_oe[TFM_P_CS3];
   endproperty
   a_r18: assert property (p_r18) else $error("unlisted code drives"); // R18

endmodule // tfm_mux

// ===== dv/tfm_mux_tb.sv
// self-checking bench for the terminal function-select multiplexer
// assumes tfm_mux as declared; inputs change on the falling edge only
module tfm_mux_tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [31:0] s7;
      logic [31:0] s8;
      logic [13:0] pin;
      logic [13:0] oe;
      logic [13:0] out;
      logic [14:0] fn;
   } tfm_row_t;

   logic        clk_sys, sys_rst;
   logic        function_select_7_we, function_select_8_we;
   logic [31:0] function_select_7_wdata, function_select_8_wdata;
   logic [31:0] function_select_7_rdata, function_select_8_rdata;
   logic [13:0] pad_in, pad_out, pad_oe;
   logic [7:0]  fixed_pin_in, fixed_pin_level;
   logic [1:0]  general_pin_o, general_pin_oe, general_pin_i;
   logic [3:0]  proc_io_o, proc_io_oe, proc_io_i;
   logic        serial_c_request_to_send, serial_periph_ready;
   logic        bus_power_sense, low_power_indicator, indicator_lamp_two;
   logic        external_transfer_request_one, external_transfer_request_zero;
   logic        three_wire_data_in, three_wire_data_out, three_wire_clock_out;
   logic        three_wire_select_zero, three_wire_select_three;
   logic        serial_c_set_ready, serial_a_set_ready;
   logic        serial_c_terminal_ready, serial_a_terminal_ready;
   logic        buffered_port_c_rx_data, buffered_port_c_tx_data;
   logic        buffered_port_c_tx_clock_o, buffered_port_c_tx_clock_oe;
   logic        buffered_port_c_tx_clock_i;
   logic        keypad_column_seven, keypad_column_six;
   logic        two_wire_clock_pull_low, two_wire_data_pull_low;
   logic        two_wire_clock_i, two_wire_data_i, test_data_out;
   logic        general_pin_nine_level, proc_io_line_three_level;
   logic        gate_class_two, gate_class_three;
   logic [14:0] fn_vec;
   int          n_mismatch = 0;
   int          cmp_count = 0;

   // core drives are chosen so every alternative except serial_a_terminal_ready differs from the primary
   tfm_row_t rows [5] = '{
      '{32'h0000_0000, 32'h0000_0000, 14'h0100, 14'h263f, 14'h2629, 15'h001c},
      '{32'h0004_9240, 32'h0000_1249, 14'h3eff, 14'h3e25, 14'h2824, 15'h0364},
      '{32'h0001_0400, 32'h0000_2412, 14'h3eff, 14'h3e3d, 14'h3621, 15'h5689},
      '{32'h0000_0000, 32'h0000_001b, 14'h0100, 14'h263f, 14'h2429, 15'h000e},
      '{32'hffff_ffff, 32'hffff_ffff, 14'h3eff, 14'h263f, 14'h2629, 15'h7e0c}
   };

   assign fn_vec = {general_pin_i, proc_io_i, serial_periph_ready,
                    bus_power_sense, external_transfer_request_one,
                    external_transfer_request_zero, three_wire_data_in,
                    serial_c_set_ready, serial_a_set_ready,
                    buffered_port_c_rx_data, buffered_port_c_tx_clock_i};

   tfm_mux tfm_mux_inst (
      .clk_sys, .sys_rst, .function_select_7_wdata, .function_select_7_we,
      .function_select_8_wdata, .function_select_8_we,
      .function_select_7_rdata, .function_select_8_rdata,
      .pad_in, .pad_out, .pad_oe, .fixed_pin_in, .fixed_pin_level,
      .general_pin_o, .general_pin_oe, .general_pin_i,
      .proc_io_o, .proc_io_oe, .proc_io_i,
      .serial_c_request_to_send, .serial_periph_ready, .bus_power_sense,
      .low_power_indicator, .external_transfer_request_one,
      .external_transfer_request_zero, .indicator_lamp_two,
      .three_wire_data_in, .three_wire_data_out, .three_wire_clock_out,
      .three_wire_select_zero, .three_wire_select_three,
      .serial_c_set_ready, .serial_a_set_ready,
      .serial_c_terminal_ready, .serial_a_terminal_ready,
      .buffered_port_c_rx_data, .buffered_port_c_tx_data,
      .buffered_port_c_tx_clock_o, .buffered_port_c_tx_clock_oe,
      .buffered_port_c_tx_clock_i, .keypad_column_seven, .keypad_column_six,
      .two_wire_clock_pull_low, .two_wire_data_pull_low,
      .two_wire_clock_i, .two_wire_data_i, .test_data_out,
      .general_pin_nine_level, .proc_io_line_three_level,
      .gate_class_two, .gate_class_three
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic wrap_up;
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] v7, input logic [31:0] v8);
      @(negedge clk_sys);
      function_select_7_wdata = v7;
      function_select_8_wdata = v8;
      function_select_7_we = 1'b1;
      function_select_8_we = 1'b1;
      @(negedge clk_sys);
      function_select_7_we = 1'b0;
      function_select_8_we = 1'b0;
   endtask

   // covers the three-edge input path, longest latency of the block
   task automatic settle;
      repeat (4) @(negedge clk_sys);
   endtask

   // hang guard
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      sys_rst = 1'b1;
      function_select_7_we = 1'b0;
      function_select_8_we = 1'b0;
      function_select_7_wdata = 32'h0000_0000;
      function_select_8_wdata = 32'h0000_0000;
      pad_in = 14'h0100;
      fixed_pin_in = 8'h00;
      general_pin_o = 2'h2;
      general_pin_oe = 2'h3;
      proc_io_o = 4'h5;
      proc_io_oe = 4'hf;
      serial_c_request_to_send = 1'b0;
      low_power_indicator = 1'b1;
      indicator_lamp_two = 1'b0;
      three_wire_data_out = 1'b1;
      three_wire_clock_out = 1'b1;
      three_wire_select_zero = 1'b1;
      three_wire_select_three = 1'b0;
      serial_c_terminal_ready = 1'b0;
      serial_a_terminal_ready = 1'b1;
      buffered_port_c_tx_data = 1'b0;
      buffered_port_c_tx_clock_o = 1'b0;
      buffered_port_c_tx_clock_oe = 1'b1;
      keypad_column_seven = 1'b0;
      keypad_column_six = 1'b1;
      two_wire_clock_pull_low = 1'b0;
      two_wire_data_pull_low = 1'b0;
      test_data_out = 1'b1;
      general_pin_nine_level = 1'b0;
      proc_io_line_three_level = 1'b0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(32'(pad_oe), 32'h0000_2600);
      chk(32'(pad_out), 32'h0000_0000);
      chk(function_select_7_rdata, 32'h0000_0000);
      chk(function_select_8_rdata, 32'h0000_0000);
      chk(32'(fn_vec), 32'h0000_000c);
      sys_rst = 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].s7, rows[i].s8);
         pad_in = rows[i].pin;
         settle();
         chk(function_select_7_rdata, rows[i].s7);
         chk(function_select_8_rdata, rows[i].s8);
         chk(32'(pad_oe), 32'(rows[i].oe));
         chk(32'(pad_out & rows[i].oe), 32'(rows[i].out));
         chk(32'(fn_vec), 32'(rows[i].fn));
         chk(32'(two_wire_clock_i), 32'(rows[i].pin[6]));
         chk(32'(two_wire_data_i), 32'(rows[i].pin[7]));
      end
      // fail gating on top of the primary functions
      wr(32'h0000_0000, 32'h0000_0000);
      pad_in = 14'h0000;
      two_wire_clock_pull_low = 1'b1;
      two_wire_data_pull_low = 1'b1;
      settle();
      chk(32'(pad_oe), 32'h0000_26ff);
      chk(32'(pad_out), 32'h0000_2629);
      fixed_pin_in = 8'ha5;
      settle();
      chk(32'(fixed_pin_level), 32'h0000_00a5);
      chk(32'(pad_oe), 32'h0000_263f);
      chk(32'(pad_out), 32'h0000_2020);
      chk(32'(gate_class_three), 32'h0000_0001);
      fixed_pin_in = 8'h25;
      settle();
      chk(32'(gate_class_three), 32'h0000_0000);
      fixed_pin_in = 8'h00;
      two_wire_clock_pull_low = 1'b0;
      two_wire_data_pull_low = 1'b0;
      for (int i = 0; i < 4; i++) begin
         general_pin_nine_level = i[1];
         proc_io_line_three_level = i[0];
         settle();
         chk(32'(gate_class_two), 32'(i == 3));
      end
      // reset again in mid-run with every field but reg8 8:6 non-zero
      wr(32'hffff_ffff, 32'h0000_2412);
      settle();
      sys_rst = 1'b1;
      @(negedge clk_sys);
      chk(32'(pad_oe), 32'h0000_2600);
      chk(32'(pad_out), 32'h0000_0000);
      chk(function_select_7_rdata, 32'h0000_0000);
      chk(function_select_8_rdata, 32'h0000_0000);
      chk(32'(fn_vec), 32'h0000_000c);
      sys_rst = 1'b0;
      settle();
      chk(32'(pad_oe), 32'h0000_263f);
      chk(32'(pad_out), 32'h0000_2629);
      wrap_up();
   end
endmodule // tfm_mux_tb
